// [logic/ctm_map.svh]
// Register offsets, field positions, reset values and timing counts.
// How it works
// - 16-bit up-counter advances on selected clock
// - Comparator P: period value versus counter bits 15:8
// - Comparator A: compare value versus all counter bits
// - Software cannot load counter, only clear it
// - Overflow or the selected match (A if clear-on-A, else P) clears counter, raises interrupt
// - Counter read-only, compare pair and period read/write
// - Counter low and high bytes map bits
// - Compare low and high bytes hold bits
// - Pause bit holds count, resumes from it
// - Clock select field picks eight sources
// - Counter-on bit runs counter, zero stops it
// - Counter-on rise clears count, fall keeps it
// - Counter-on rise sets output to initial level in compare mode
// - Control 0 bits 2 to 0 read zero
// - Three modes: compare, timer/counter, PWM
// - Low write buffered, high write transfers both
// - High read buffers low, low read returns buffer
`ifndef CTM_MAP_SVH
`define CTM_MAP_SVH

`define CTM_OFF_CTRL0 8'h00
`define CTM_OFF_CTRL1 8'h04
`define CTM_OFF_CNT_LO 8'h08
`define CTM_OFF_CNT_HI 8'h0C
`define CTM_OFF_CMP_LO 8'h10
`define CTM_OFF_CMP_HI 8'h14
`define CTM_OFF_PERIOD 8'h18
`define CTM_OFF_INT_STAT 8'h1C
`define CTM_OFF_INT_MASK 8'h20

`define CTM_CTRL0_RST 8'h00
`define CTM_CTRL1_RST 8'h00
`define CTM_PERIOD_RST 8'h00
`define CTM_CMP_RST 16'h0000
`define CTM_CTRL0_WMASK 8'hF8

`define CTM_INT_P 0
`define CTM_INT_A 1
`define CTM_INT_OVF 2
`define CTM_INT_W 3

`define CTM_CK_SYS4 3'h0
`define CTM_CK_SYS 3'h1
`define CTM_CK_H16 3'h2
`define CTM_CK_H64 3'h3
`define CTM_CK_TBC 3'h4
`define CTM_CK_H8 3'h5
`define CTM_CK_PIN_RISE 3'h6
`define CTM_CK_PIN_FALL 3'h7

`define CTM_DIV_W 6
`define CTM_DIV4_MASK 6'h03
`define CTM_DIV8_MASK 6'h07
`define CTM_DIV16_MASK 6'h0F
`define CTM_DIV64_MASK 6'h3F

`endif

// [logic/ctm_pkg.sv]
// Types shared by the compact timer core.
package ctm_pkg;

  typedef enum logic [1:0] {
    CTM_MODE_CMP = 2'h0,
    CTM_MODE_RSV = 2'h1,
    CTM_MODE_PWM = 2'h2,
    CTM_MODE_TMR = 2'h3
  } ctm_mode_t;

  typedef enum logic [1:0] {
    CTM_IO_HOLD = 2'h0,
    CTM_IO_LOW = 2'h1,
    CTM_IO_HIGH = 2'h2,
    CTM_IO_TOGGLE = 2'h3
  } ctm_io_t;

  typedef struct packed {
    logic pause;
    logic [2:0] clk_sel;
    logic on;
    logic [2:0] rsv;
  } ctm_ctrl0_t;

  typedef struct packed {
    ctm_mode_t mode;
    ctm_io_t io;
    logic init_level;
    logic polarity;
    logic pwm_active_low;
    logic clear_on_a;
  } ctm_ctrl1_t;

endpackage

// [logic/ctm_top.sv]
// Compact 16-bit timer core with an APB register slave.
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "ctm_map.svh"

module ctm_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timebase_tick,
  input wire logic external_clock_pin,
  output logic timer_output_pin,
  output logic irq
);

  ctm_pkg::ctm_ctrl0_t ctrl0_reg;
  ctm_pkg::ctm_ctrl1_t ctrl1_reg;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [15:0] cmp_a_reg;
  logic [7:0] period_reg;
  logic [7:0] hold_buf_reg;
  logic [7:0] hold_buf_next;
  logic [`CTM_INT_W-1:0] stat_reg;
  logic [`CTM_INT_W-1:0] stat_next;
  logic [`CTM_INT_W-1:0] mask_reg;
  logic [`CTM_DIV_W-1:0] div_reg;
  logic [2:0] pin_sync_reg;
  logic out_state_reg;
  logic out_state_next;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic pin_reg;
  logic irq_reg;

  // Bus decode.
  wire access = psel && penable;
  wire xfer = access && pready_reg;
  wire wr = xfer && pwrite;
  // Reads act when the read data is captured, so that a buffered low byte
  // comes from the same count as the high byte returned with it.
  wire rd = access && !pready_reg && !pwrite;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  wire sel_c0 = hit(paddr, `CTM_OFF_CTRL0);
  wire sel_c1 = hit(paddr, `CTM_OFF_CTRL1);
  wire sel_dl = hit(paddr, `CTM_OFF_CNT_LO);
  wire sel_dh = hit(paddr, `CTM_OFF_CNT_HI);
  wire sel_al = hit(paddr, `CTM_OFF_CMP_LO);
  wire sel_ah = hit(paddr, `CTM_OFF_CMP_HI);
  wire sel_rp = hit(paddr, `CTM_OFF_PERIOD);
  wire sel_st = hit(paddr, `CTM_OFF_INT_STAT);
  wire sel_mk = hit(paddr, `CTM_OFF_INT_MASK);
  wire sel_any = sel_c0 || sel_c1 || sel_dl || sel_dh || sel_al ||
                 sel_ah || sel_rp || sel_st || sel_mk;

  wire wr_c0 = wr && sel_c0;
  wire wr_c1 = wr && sel_c1;
  wire wr_al = wr && sel_al;
  wire wr_ah = wr && sel_ah;
  wire wr_rp = wr && sel_rp;
  wire wr_st = wr && sel_st;
  wire wr_mk = wr && sel_mk;
  wire rd_dh = rd && sel_dh;
  wire rd_ah = rd && sel_ah;

  // Counter-on going from 0 to 1 is the only software action on the count.
  wire on_rise = wr_c0 && pwdata[3] && !ctrl0_reg.on;

  // Read data; low byte reads return the holding buffer.
  wire [7:0] rd_byte =
    sel_c0 ? {ctrl0_reg[7:3], 3'h0} :
    sel_c1 ? ctrl1_reg :
    sel_dl ? hold_buf_reg :
    sel_dh ? cnt_reg[15:8] :
    sel_al ? hold_buf_reg :
    sel_ah ? cmp_a_reg[15:8] :
    sel_rp ? period_reg :
    sel_st ? {5'h00, stat_reg} :
    sel_mk ? {5'h00, mask_reg} : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= access && !pready_reg;
      pslverr_reg <= access && !pready_reg && !sel_any;
      if (access && !pready_reg) begin
        prdata_reg <= {24'h00_0000, rd_byte};
      end
    end
  end

  // One shared buffer serves both low byte procedures.
  assign hold_buf_next =
    wr_al ? pwdata[7:0] :
    rd_dh ? cnt_reg[7:0] :
    rd_ah ? cmp_a_reg[7:0] : hold_buf_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_reg <= `CTM_CTRL0_RST;
      ctrl1_reg <= `CTM_CTRL1_RST;
      period_reg <= `CTM_PERIOD_RST;
      cmp_a_reg <= `CTM_CMP_RST;
      hold_buf_reg <= 8'h00;
      mask_reg <= 3'h0;
    end else begin
      hold_buf_reg <= hold_buf_next;
      if (wr_c0) begin
        ctrl0_reg <= pwdata[7:0] & `CTM_CTRL0_WMASK;
      end
      if (wr_c1) begin
        ctrl1_reg <= pwdata[7:0];
      end
      if (wr_rp) begin
        period_reg <= pwdata[7:0];
      end
      if (wr_ah) begin
        cmp_a_reg <= {pwdata[7:0], hold_buf_reg};
      end
      if (wr_mk) begin
        mask_reg <= pwdata[`CTM_INT_W-1:0];
      end
    end
  end

  // Prescaler; the high clock is taken to equal pclk.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 6'h00;
    end else begin
      div_reg <= div_reg + 6'h01;
    end
  end

  // The first synchroniser stage feeds only the second.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync_reg <= 3'h0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[1:0], external_clock_pin};
    end
  end

  wire pin_rise = pin_sync_reg[1] && !pin_sync_reg[2];
  wire pin_fall = !pin_sync_reg[1] && pin_sync_reg[2];

  wire div4 = (div_reg & `CTM_DIV4_MASK) == `CTM_DIV4_MASK;
  wire div8 = (div_reg & `CTM_DIV8_MASK) == `CTM_DIV8_MASK;
  wire div16 = (div_reg & `CTM_DIV16_MASK) == `CTM_DIV16_MASK;
  wire div64 = div_reg == `CTM_DIV64_MASK;

  logic tick;
  always_comb begin
    unique case (ctrl0_reg.clk_sel)
      `CTM_CK_SYS4: tick = div4;
      `CTM_CK_SYS: tick = 1'b1;
      `CTM_CK_H16: tick = div16;
      `CTM_CK_H64: tick = div64;
      `CTM_CK_TBC: tick = timebase_tick;
      `CTM_CK_H8: tick = div8;
      `CTM_CK_PIN_RISE: tick = pin_rise;
      `CTM_CK_PIN_FALL: tick = pin_fall;
    endcase
  end

  // Counting runs only while on and not paused.
  wire count_en = tick && ctrl0_reg.on && !ctrl0_reg.pause;

  wire match_a = cnt_reg == cmp_a_reg;
  wire match_p = cnt_reg[15:8] == period_reg;
  wire ovf = cnt_reg == 16'hFFFF;
  wire clr_match = ctrl1_reg.clear_on_a ? match_a : match_p;

  wire ev_p = count_en && match_p;
  wire ev_a = count_en && match_a;
  wire ev_ovf = count_en && ovf;

  assign cnt_next =
    on_rise ? 16'h0000 :
    !count_en ? cnt_reg :
    (ovf || clr_match) ? 16'h0000 :
    cnt_reg + 16'h0001;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Hardware set wins over a write-one-to-clear in the same cycle.
  wire [`CTM_INT_W-1:0] ev_vec = {ev_ovf, ev_a, ev_p};
  wire [`CTM_INT_W-1:0] w1c = wr_st ? pwdata[`CTM_INT_W-1:0] : 3'h0;
  assign stat_next = (stat_reg & ~w1c) | ev_vec;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg <= 3'h0;
      irq_reg <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      irq_reg <= |(stat_reg & mask_reg);
    end
  end

  // Output stage per operating mode.
  wire pwm_lvl = (cnt_reg < cmp_a_reg) ^ ctrl1_reg.pwm_active_low;

  always_comb begin
    out_state_next = out_state_reg;
    unique case (ctrl1_reg.mode)
      ctm_pkg::CTM_MODE_CMP: begin
        if (on_rise) begin
          out_state_next = ctrl1_reg.init_level;
        end else if (ev_a) begin
          unique case (ctrl1_reg.io)
            ctm_pkg::CTM_IO_HOLD: out_state_next = out_state_reg;
            ctm_pkg::CTM_IO_LOW: out_state_next = 1'b0;
            ctm_pkg::CTM_IO_HIGH: out_state_next = 1'b1;
            ctm_pkg::CTM_IO_TOGGLE: out_state_next = !out_state_reg;
          endcase
        end
      end
      ctm_pkg::CTM_MODE_PWM: begin
        out_state_next = ctrl0_reg.on ? pwm_lvl : ctrl1_reg.init_level;
      end
      ctm_pkg::CTM_MODE_TMR: out_state_next = out_state_reg;
      ctm_pkg::CTM_MODE_RSV: out_state_next = out_state_reg;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_state_reg <= 1'b0;
      pin_reg <= 1'b0;
    end else begin
      out_state_reg <= out_state_next;
      pin_reg <= out_state_reg ^ ctrl1_reg.polarity;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign timer_output_pin = pin_reg;
  assign irq = irq_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wr_high;
    wr_ah;
  endsequence

  sequence s_rd_cnt_high;
    rd_dh;
  endsequence

  pause_hold_a: assert property (
    ctrl0_reg.pause && !on_rise |=> $stable(cnt_reg))
    else $error("Counter moved while paused.");

  off_hold_a: assert property (
    !ctrl0_reg.on && !on_rise |=> $stable(cnt_reg))
    else $error("Counter moved while off.");

  on_clear_a: assert property (
    on_rise |=> cnt_reg == 16'h0000 && ctrl0_reg.on)
    else $error("Counter not cleared on switch-on.");

  count_step_a: assert property (
    count_en && !on_rise && !ovf && !clr_match
    |=> cnt_reg == $past(cnt_reg) + 16'h0001)
    else $error("Counter did not advance by one.");

  wrap_flag_a: assert property (
    count_en && !on_rise && ovf
    |=> cnt_reg == 16'h0000 && stat_reg[`CTM_INT_OVF])
    else $error("Overflow wrap or flag missing.");

  cmp_a_clear_a: assert property (
    count_en && !on_rise && ctrl1_reg.clear_on_a && match_a
    |=> cnt_reg == 16'h0000 && stat_reg[`CTM_INT_A])
    else $error("Compare A match did not clear counter.");

  cmp_p_clear_a: assert property (
    count_en && !on_rise && !ctrl1_reg.clear_on_a &&
    cnt_reg[15:8] == period_reg |=> cnt_reg == 16'h0000)
    else $error("Period match did not clear counter.");

  wr_buffer_a: assert property (
    s_wr_high |=> cmp_a_reg == {$past(pwdata[7:0]), $past(hold_buf_reg)})
    else $error("Compare pair not transferred from buffer.");

  rd_buffer_a: assert property (
    s_rd_cnt_high |=> hold_buf_reg == $past(cnt_reg[7:0]))
    else $error("Counter low byte not buffered on high read.");

  ctrl_zero_a: assert property (
    pready_reg && sel_c0 && !pwrite |-> prdata_reg[2:0] == 3'h0)
    else $error("Unimplemented control bits read nonzero.");

  init_level_a: assert property (
    on_rise && ctrl1_reg.mode == ctm_pkg::CTM_MODE_CMP
    |=> out_state_reg == $past(ctrl1_reg.init_level))
    else $error("Output not set to initial level.");

  no_load_a: assert property (
    !on_rise && !count_en |=> $stable(cnt_reg))
    else $error("Counter changed without a count or switch-on.");

  period_flag_a: assert property (
    count_en && match_p |=> stat_reg[`CTM_INT_P])
    else $error("Period match flag not set.");

  irq_raise_a: assert property (
    |(stat_reg & mask_reg) |=> irq_reg)
    else $error("Interrupt not raised for unmasked status.");

  irq_drop_a: assert property (
    !(|(stat_reg & mask_reg)) |=> !irq_reg)
    else $error("Interrupt raised with no unmasked status.");

  ready_pulse_a: assert property (
    pready_reg |=> !pready_reg)
    else $error("Ready held for more than one cycle.");

endmodule

// [dv/ctm_pin_model.sv]
// Far-side model: external clock source and output pin load.
`timescale 1ns/100ps
module ctm_pin_model (
  input wire logic pclk,
  input wire logic out_pin,
  output logic ext_pin
);
  logic load_level;
  initial ext_pin = 1'b0;
  always @(posedge pclk) begin
    load_level <= out_pin;
  end
  // The source idles low between bursts; hw sets a fast or slow edge rate.
  task automatic pulses(input int n, input int hw);
    repeat (n) begin
      repeat (hw) @(posedge pclk);
      ext_pin <= 1'b1;
      repeat (hw) @(posedge pclk);
      ext_pin <= 1'b0;
    end
  endtask
endmodule

// [dv/compact_timer_counter_core_tb.sv]
// Self-checking bench for the compact timer core.
`timescale 1ns/100ps
module compact_timer_counter_core_tb;
  logic pclk, presetn, psel, penable, pwrite, tick, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, ext_pin, out_pin, irq;
  logic [15:0] c0, c1;
  int n_mismatch = 0;
  int compares = 0;
  int w;

  ctm_top ctm_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timebase_tick(tick), .external_clock_pin(ext_pin),
    .timer_output_pin(out_pin), .irq(irq));
  ctm_pin_model pin_i (.pclk(pclk), .out_pin(out_pin), .ext_pin(ext_pin));

  task automatic close_out();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t byte %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t flag %b exp %b", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr_en, input logic [7:0] a,
    input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdm(input logic [7:0] a, m, exp);
    apb(1'b0, a, 8'h00);
    chk8(rd[7:0] & m, exp);
  endtask

  // High byte first so the low byte comes from the same snapshot.
  task automatic rcnt(output logic [15:0] c);
    apb(1'b0, 8'h0C, 8'h00);
    c[15:8] = rd[7:0];
    apb(1'b0, 8'h08, 8'h00);
    c[7:0] = rd[7:0];
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge pclk);
      tick <= 1'b1;
      @(posedge pclk);
      tick <= 1'b0;
    end
  endtask

  task automatic wirq(input int b, output int i);
    i = 0;
    while (irq !== 1'b1 && i < b) begin
      @(posedge pclk);
      i++;
    end
    chk1(irq, 1'b1);
    if (i >= b) begin
      close_out();
    end
  endtask

  task automatic s_regs();
    for (int a = 0; a <= 32; a += 4) begin
      rdm(8'(a), 8'hFF, 8'h00);
    end
    apb(1'b0, 8'h24, 8'h00);
    chk1(err, 1'b1);
    wr(8'h00, 8'h77);
    rdm(8'h00, 8'hFF, 8'h70);
    wr(8'h0C, 8'hAB);
    rdm(8'h0C, 8'hFF, 8'h00);
    wr(8'h10, 8'h34);
    rdm(8'h14, 8'hFF, 8'h00);
    rdm(8'h10, 8'hFF, 8'h00);
    wr(8'h10, 8'h34);
    wr(8'h14, 8'h12);
    rdm(8'h14, 8'hFF, 8'h12);
    rdm(8'h10, 8'hFF, 8'h34);
  endtask

  task automatic s_onoff();
    wr(8'h04, 8'h01);
    wr(8'h18, 8'hFF);
    wr(8'h10, 8'hFF);
    wr(8'h14, 8'hFF);
    wr(8'h00, 8'h18);
    repeat (20) @(posedge pclk);
    wr(8'h00, 8'h10);
    rcnt(c0);
    repeat (10) @(posedge pclk);
    rcnt(c1);
    chk8(c1[7:0], c0[7:0]);
    chk1(c0 > 16'd20, 1'b1);
    wr(8'h00, 8'h48);
    rcnt(c0);
    chk8(c0[7:0], 8'h00);
    ticks(5);
    rcnt(c0);
    chk8(c0[7:0], 8'h05);
    wr(8'h00, 8'hC8);
    ticks(3);
    rcnt(c0);
    chk8(c0[7:0], 8'h05);
    wr(8'h00, 8'h48);
    ticks(2);
    rcnt(c0);
    chk8(c0[7:0], 8'h07);
  endtask

  task automatic s_clocks();
    logic [2:0] sl [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};
    int dv [5] = '{4, 1, 16, 64, 8};
    for (int k = 6; k < 8; k++) begin
      wr(8'h00, {1'b0, 3'(k), 4'h0});
      wr(8'h00, {1'b0, 3'(k), 4'h8});
      pin_i.pulses(4, k - 4);
      repeat (4) @(posedge pclk);
      rcnt(c0);
      chk8(c0[7:0], 8'h04);
    end
    for (int k = 0; k < 5; k++) begin
      wr(8'h00, {1'b0, sl[k], 4'h0});
      wr(8'h00, {1'b0, sl[k], 4'h8});
      repeat (256) @(posedge pclk);
      wr(8'h00, {1'b0, sl[k], 4'h0});
      rcnt(c0);
      chk1(c0 >= 16'(256 / dv[k] - 1) && c0 <= 16'(264 / dv[k] + 1),
        1'b1);
    end
  endtask

  task automatic s_match();
    wr(8'h10, 8'h05);
    wr(8'h14, 8'h00);
    wr(8'h1C, 8'hFF);
    wr(8'h00, 8'h48);
    ticks(5);
    rcnt(c0);
    chk8(c0[7:0], 8'h05);
    rdm(8'h1C, 8'h02, 8'h00);
    ticks(1);
    rcnt(c0);
    chk8(c0[7:0], 8'h00);
    rdm(8'h1C, 8'h02, 8'h02);
    wr(8'h1C, 8'h02);
    rdm(8'h1C, 8'h02, 8'h00);
  endtask

  task automatic s_ovf();
    wr(8'h00, 8'h40);
    wr(8'h10, 8'hFF);
    wr(8'h14, 8'hFF);
    wr(8'h20, 8'h04);
    wr(8'h00, 8'h18);
    wirq(70000, w);
    chk1(w > 65000, 1'b1);
    rdm(8'h1C, 8'h04, 8'h04);
    rcnt(c0);
    chk1(c0 < 16'd100, 1'b1);
    wr(8'h20, 8'h00);
    repeat (2) @(posedge pclk);
    chk1(irq, 1'b0);
    wr(8'h00, 8'h10);
    wr(8'h1C, 8'hFF);
    wr(8'h20, 8'h04);
    repeat (2) @(posedge pclk);
    chk1(irq, 1'b0);
    // Period match only on the upper byte, so it cannot fire early.
    wr(8'h04, 8'h00);
    wr(8'h18, 8'h01);
    wr(8'h20, 8'h01);
    wr(8'h00, 8'h18);
    wirq(2000, w);
    chk1(w > 240, 1'b1);
    wr(8'h00, 8'h10);
    rcnt(c0);
    chk1(c0[15:8] <= 8'h01, 1'b1);
  endtask

  task automatic s_outpin();
    wr(8'h00, 8'h40);
    wr(8'h04, 8'h08);
    wr(8'h00, 8'h48);
    repeat (2) @(posedge pclk);
    chk1(out_pin, 1'b1);
    wr(8'h00, 8'h40);
    wr(8'h04, 8'h00);
    wr(8'h00, 8'h48);
    repeat (2) @(posedge pclk);
    chk1(out_pin, 1'b0);
  endtask

  // PWM level against compare A, then a toggling match with inverted pin.
  task automatic s_modes();
    wr(8'h00, 8'h40);
    wr(8'h10, 8'h03);
    wr(8'h14, 8'h00);
    wr(8'h04, 8'h80);
    wr(8'h00, 8'h48);
    repeat (3) @(posedge pclk);
    chk1(out_pin, 1'b1);
    ticks(3);
    repeat (3) @(posedge pclk);
    chk1(out_pin, 1'b0);
    wr(8'h00, 8'h40);
    wr(8'h04, 8'h35);
    wr(8'h00, 8'h48);
    repeat (2) @(posedge pclk);
    chk1(out_pin, 1'b1);
    ticks(4);
    repeat (2) @(posedge pclk);
    chk1(out_pin, 1'b0);
  endtask

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    tick = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    s_regs();
    s_onoff();
    s_clocks();
    s_match();
    s_ovf();
    s_outpin();
    s_modes();
    close_out();
  end
endmodule
